/* File: exec_consts.vh */
// constants for the execution and effective-address unit
`ifndef EXEC_CONSTS_VH
`define EXEC_CONSTS_VH

// ****************************************
// operation select codes
// ****************************************
`define OP_EA_CALC 4'h0
`define OP_STOP 4'h1
`define OP_MINUS_WITH_EXTEND 4'h2
`define OP_SWAP 4'h3
`define OP_TAS 4'h4
`define OP_TST 4'h5
`define OP_TRAP 4'h6
`define OP_FRAME_RELEASE 4'h7
`define OP_MOVE 4'h8

// ****************************************
// effective address modes
// ****************************************
`define EA_DREG 4'h0
`define EA_AREG 4'h1
`define EA_IND 4'h2
`define EA_POSTINC 4'h3
`define EA_PREDEC 4'h4
`define EA_DISP 4'h5
`define EA_INDEX 4'h6
`define EA_ABS_S 4'h7
`define EA_ABS_L 4'h8
`define EA_PC_DISP 4'h9
`define EA_PC_INDEX 4'ha
`define EA_IMM 4'hb
`define EA_IMPLIED 4'hc

// ****************************************
// implied register select
// ****************************************
`define IMP_SR 3'h0
`define IMP_USP 3'h1
`define IMP_SSP 3'h2
`define IMP_PC 3'h3
`define IMP_SP 3'h4

// ****************************************
// operand sizes and step sizes
// ****************************************
`define SZ_BYTE 2'h0
`define SZ_WORD 2'h1
`define SZ_LONG 2'h2
`define STEP_BYTE 32'h00000001
`define STEP_WORD 32'h00000002
`define STEP_LONG 32'h00000004

// ****************************************
// status register flag positions
// ****************************************
`define FLAG_X 4
`define FLAG_N 3
`define FLAG_Z 2
`define FLAG_V 1
`define FLAG_C 0
`define TAS_MARK_BIT 7
`define STATUS_RESET 16'h2700

// ****************************************
// address calculation cost, clocks only
// ****************************************
`define CK_IND_BW 7'h04
`define CK_IND_L 7'h08
`define CK_PRE_BW 7'h07
`define CK_PRE_L 7'h0b
`define CK_DISP_BW 7'h0b
`define CK_DISP_L 7'h0c
`define CK_INDEX_BW 7'h0e
`define CK_INDEX_L 7'h08
`define CK_ABS_S_BW 7'h08
`define CK_ABS_S_L 7'h0c
`define CK_ABS_L_BW 7'h0c
`define CK_ABS_L_L 7'h10
`define CK_PCD_BW 7'h0b
`define CK_PCD_L 7'h0f
`define CK_PCX_BW 7'h0e
`define CK_PCX_L 7'h10
`define CK_IMM_BW 7'h04
`define CK_IMM_L 7'h08

// ****************************************
// byte or word move cost
// ****************************************
`define CK_MOVE_RR 7'h07
`define RD_MOVE_RR 4'h1
`define CK_MOVE_RI 7'h0b
`define RD_MOVE_RI 4'h1
`define WR_MOVE_RI 4'h1

`endif

/* File: ea_cost.v */
// address calculation cost lookup with narrow bus doubling
`timescale 1ns/1ps
module ea_cost (
  input wire [3:0] ea_mode,
  input wire is_long,
  input wire bus8,
  output reg [6:0] clocks,
  output reg [3:0] reads
);
`include "exec_consts.vh"

  reg [3:0] rd_base;

  always @* begin
    clocks = 7'h00;
    rd_base = 4'h0;
    case (ea_mode)
      `EA_IND, `EA_POSTINC: begin
        clocks = is_long ? `CK_IND_L : `CK_IND_BW;
        rd_base = is_long ? 4'h2 : 4'h1;
      end
      `EA_PREDEC: begin
        clocks = is_long ? `CK_PRE_L : `CK_PRE_BW;
        rd_base = is_long ? 4'h2 : 4'h1;
      end
      `EA_DISP: begin
        clocks = is_long ? `CK_DISP_L : `CK_DISP_BW;
        rd_base = is_long ? 4'h3 : 4'h2;
      end
      `EA_INDEX: begin
        clocks = is_long ? `CK_INDEX_L : `CK_INDEX_BW;
        rd_base = is_long ? 4'h3 : 4'h2;
      end
      `EA_ABS_S: begin
        clocks = is_long ? `CK_ABS_S_L : `CK_ABS_S_BW;
        rd_base = is_long ? 4'h3 : 4'h2;
      end
      `EA_ABS_L: begin
        clocks = is_long ? `CK_ABS_L_L : `CK_ABS_L_BW;
        rd_base = is_long ? 4'h4 : 4'h3;
      end
      `EA_PC_DISP: begin
        clocks = is_long ? `CK_PCD_L : `CK_PCD_BW;
        rd_base = is_long ? 4'h3 : 4'h2;
      end
      `EA_PC_INDEX: begin
        clocks = is_long ? `CK_PCX_L : `CK_PCX_BW;
        rd_base = is_long ? 4'h4 : 4'h2;
      end
      `EA_IMM: begin
        clocks = is_long ? `CK_IMM_L : `CK_IMM_BW;
        rd_base = is_long ? 4'h2 : 4'h1;
      end
      // register direct and implied add nothing
      default: begin
        clocks = 7'h00;
        rd_base = 4'h0;
      end
    endcase
    // narrow bus: every bus cycle count doubles, clocks stay
    reads = bus8 ? {rd_base[2:0], 1'b0} : rd_base;
  end

endmodule // ea_cost

/* File: exec_unit.v */
// instruction execution, effective address and cycle cost unit
// How it works
// - load status from immediate, then halt
// - destination minus source minus extend, flags
// - swap register halves, flag N Z, clear V C
// - test operand flags, then mark bit 7
// - test operand flags only, operand untouched
// - push pc then status, load vector
// - stack from address reg, pop long into it
// - post-increment after, pre-decrement before, by size
// - offset: base plus 16-bit displacement
// - absolute short one word, long two words
// - implied mode selects a special register
// - narrow bus doubles all bus cycle counts
// - direct free; indirect 4/1 or 8/2
// - pre-decrement costs 7/1 or 11/2
// - pc displacement costs 11/2 or 15/3
// - indexed address register costs 14/2 or 8/3
// - register moves 7/1; to indirect 11/1/1
`timescale 1ns/1ps
module exec_unit (
  input wire clock,
  input wire rst_n,
  input wire clk_en,
  input wire req_valid,
  input wire [3:0] op_sel,
  input wire [1:0] op_size,
  input wire [3:0] ea_mode,
  input wire [2:0] implied_sel,
  input wire move_dst_ind,
  input wire [31:0] src_operand,
  input wire [31:0] dst_operand,
  input wire [31:0] addr_reg,
  input wire [31:0] index_reg,
  input wire [31:0] program_counter,
  input wire [15:0] ext_word0,
  input wire [15:0] ext_word1,
  input wire [15:0] status_reg,
  input wire [31:0] user_stack_pointer,
  input wire [31:0] supervisor_stack_pointer,
  input wire [31:0] active_stack_pointer,
  input wire [31:0] trap_vector,
  input wire [31:0] pop_data,
  input wire resume,
  input wire bus8_pin,
  output reg busy_q,
  output reg done_q,
  output reg halted_q,
  output reg [31:0] result_q,
  output reg result_we_q,
  output reg [15:0] status_out_q,
  output reg [31:0] effective_addr_q,
  output reg [31:0] addr_reg_new_q,
  output reg addr_reg_we_q,
  output reg [31:0] stack_ptr_new_q,
  output reg stack_ptr_we_q,
  output reg [31:0] pc_new_q,
  output reg pc_we_q,
  output reg [31:0] push_pc_addr_q,
  output reg [31:0] push_sr_addr_q,
  output reg [6:0] clocks_q,
  output reg [3:0] reads_q,
  output reg [3:0] writes_q
);
`include "exec_consts.vh"

  // ****************************************
  // state encoding
  // ****************************************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_HALT = 3'b100;

  reg [2:0] state_q;
  reg [6:0] wait_q;
  reg stop_pend_q;
  reg bus8_s1_q;
  reg bus8_s2_q;
  reg bus8_s3_q;
  reg bus8_q;

  // ****************************************
  // helpers
  // ****************************************
  function msb_of;
    input [31:0] v;
    input [1:0] sz;
    begin
      case (sz)
        `SZ_BYTE: msb_of = v[7];
        `SZ_WORD: msb_of = v[15];
        default: msb_of = v[31];
      endcase
    end
  endfunction

  function [31:0] size_mask;
    input [1:0] sz;
    begin
      case (sz)
        `SZ_BYTE: size_mask = 32'h000000ff;
        `SZ_WORD: size_mask = 32'h0000ffff;
        default: size_mask = 32'hffffffff;
      endcase
    end
  endfunction

  // ****************************************
  // narrow bus pin synchroniser
  // ****************************************
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus8_s1_q <= 1'b0;
      bus8_s2_q <= 1'b0;
      bus8_s3_q <= 1'b0;
      bus8_q <= 1'b0;
    end else if (clk_en) begin
      bus8_s1_q <= bus8_pin;
      bus8_s2_q <= bus8_s1_q;
      bus8_s3_q <= bus8_s2_q;
      // change taken only once two stages agree
      if (bus8_s2_q == bus8_s3_q) begin
        bus8_q <= bus8_s3_q;
      end
    end
  end

  // ****************************************
  // cost of the address calculation
  // ****************************************
  wire [6:0] ea_clocks;
  wire [3:0] ea_reads;

  ea_cost u_ea_cost (
    .ea_mode(ea_mode),
    .is_long(op_size == `SZ_LONG),
    .bus8(bus8_q),
    .clocks(ea_clocks),
    .reads(ea_reads)
  );

  // ****************************************
  // effective address generation
  // ****************************************
  reg [31:0] step;
  reg [31:0] ea_d;
  reg [31:0] an_upd_d;
  reg an_upd_we;
  reg [31:0] disp16;
  reg [31:0] disp8;

  always @* begin
    case (op_size)
      `SZ_BYTE: step = `STEP_BYTE;
      `SZ_WORD: step = `STEP_WORD;
      default: step = `STEP_LONG;
    endcase
    disp16 = {{16{ext_word0[15]}}, ext_word0};
    disp8 = {{24{ext_word0[7]}}, ext_word0[7:0]};
    ea_d = 32'h00000000;
    an_upd_d = addr_reg;
    an_upd_we = 1'b0;
    case (ea_mode)
      `EA_DREG: ea_d = dst_operand;
      `EA_AREG: ea_d = addr_reg;
      `EA_IND: ea_d = addr_reg;
      `EA_POSTINC: begin
        ea_d = addr_reg;
        an_upd_d = addr_reg + step;
        an_upd_we = 1'b1;
      end
      `EA_PREDEC: begin
        an_upd_d = addr_reg - step;
        ea_d = addr_reg - step;
        an_upd_we = 1'b1;
      end
      `EA_DISP: ea_d = addr_reg + disp16;
      `EA_INDEX: ea_d = addr_reg + index_reg + disp8;
      `EA_ABS_S: ea_d = disp16;
      `EA_ABS_L: ea_d = {ext_word0, ext_word1};
      `EA_PC_DISP: ea_d = program_counter + disp16;
      `EA_PC_INDEX: ea_d = program_counter + index_reg + disp8;
      `EA_IMM: ea_d = (op_size == `SZ_LONG) ? {ext_word0, ext_word1} : disp16;
      `EA_IMPLIED: begin
        case (implied_sel)
          `IMP_SR: ea_d = {16'h0000, status_reg};
          `IMP_USP: ea_d = user_stack_pointer;
          `IMP_SSP: ea_d = supervisor_stack_pointer;
          `IMP_PC: ea_d = program_counter;
          default: ea_d = active_stack_pointer;
        endcase
      end
      default: ea_d = 32'h00000000;
    endcase
  end

  // ****************************************
  // operation results and flags
  // ****************************************
  reg [31:0] res_d;
  reg res_we;
  reg [15:0] sr_d;
  reg [32:0] diff;
  reg [31:0] mask;
  reg [31:0] s_m;
  reg [31:0] d_m;
  reg [31:0] swapped;
  reg [31:0] sp_d;
  reg sp_we;
  reg [31:0] pc_d;
  reg pc_we;
  reg [31:0] an_d;
  reg an_we;
  reg stop_d;

  always @* begin
    mask = size_mask(op_size);
    s_m = src_operand & mask;
    d_m = dst_operand & mask;
    diff = {1'b0, d_m} - {1'b0, s_m} - {32'h00000000, status_reg[`FLAG_X]};
    swapped = {dst_operand[15:0], dst_operand[31:16]};
    res_d = dst_operand;
    res_we = 1'b0;
    sr_d = status_reg;
    sp_d = active_stack_pointer;
    sp_we = 1'b0;
    pc_d = program_counter;
    pc_we = 1'b0;
    an_d = an_upd_d;
    an_we = an_upd_we;
    stop_d = 1'b0;
    case (op_sel)
      `OP_STOP: begin
        sr_d = ext_word0;
        stop_d = 1'b1;
      end
      `OP_MINUS_WITH_EXTEND: begin
        res_d = (dst_operand & ~mask) | (diff[31:0] & mask);
        res_we = 1'b1;
        sr_d[`FLAG_C] = diff[32];
        sr_d[`FLAG_X] = diff[32];
        sr_d[`FLAG_N] = msb_of(diff[31:0], op_size);
        sr_d[`FLAG_Z] = ((diff[31:0] & mask) == 32'h00000000);
        sr_d[`FLAG_V] = (msb_of(d_m, op_size) ^ msb_of(s_m, op_size)) &
                        (msb_of(diff[31:0], op_size) ^ msb_of(d_m, op_size));
      end
      `OP_SWAP: begin
        res_d = swapped;
        res_we = 1'b1;
        sr_d[`FLAG_N] = swapped[31];
        sr_d[`FLAG_Z] = (swapped == 32'h00000000);
        sr_d[`FLAG_V] = 1'b0;
        sr_d[`FLAG_C] = 1'b0;
      end
      `OP_TAS: begin
        sr_d[`FLAG_N] = dst_operand[7];
        sr_d[`FLAG_Z] = (dst_operand[7:0] == 8'h00);
        sr_d[`FLAG_V] = 1'b0;
        sr_d[`FLAG_C] = 1'b0;
        res_d = dst_operand;
        res_d[`TAS_MARK_BIT] = 1'b1;
        res_we = 1'b1;
      end
      `OP_TST: begin
        sr_d[`FLAG_N] = msb_of(dst_operand, op_size);
        sr_d[`FLAG_Z] = (d_m == 32'h00000000);
        sr_d[`FLAG_V] = 1'b0;
        sr_d[`FLAG_C] = 1'b0;
      end
      `OP_TRAP: begin
        // pc sits above status in the new frame
        sp_d = supervisor_stack_pointer - 32'h00000006;
        sp_we = 1'b1;
        pc_d = trap_vector;
        pc_we = 1'b1;
      end
      `OP_FRAME_RELEASE: begin
        // pop comes from the old frame pointer value
        sp_d = addr_reg + `STEP_LONG;
        sp_we = 1'b1;
        an_d = pop_data;
        an_we = 1'b1;
      end
      default: begin
        res_d = dst_operand;
      end
    endcase
  end

  // ****************************************
  // total cost of the request
  // ****************************************
  reg [6:0] ck_d;
  reg [3:0] rd_d;
  reg [3:0] wr_d;

  always @* begin
    ck_d = ea_clocks;
    rd_d = ea_reads;
    wr_d = 4'h0;
    if (op_sel == `OP_MOVE) begin
      if (move_dst_ind) begin
        ck_d = `CK_MOVE_RI;
        rd_d = bus8_q ? (`RD_MOVE_RI << 1) : `RD_MOVE_RI;
        wr_d = bus8_q ? (`WR_MOVE_RI << 1) : `WR_MOVE_RI;
      end else begin
        ck_d = `CK_MOVE_RR;
        rd_d = bus8_q ? (`RD_MOVE_RR << 1) : `RD_MOVE_RR;
      end
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      wait_q <= 7'h00;
      stop_pend_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      halted_q <= 1'b0;
      result_q <= 32'h00000000;
      result_we_q <= 1'b0;
      status_out_q <= `STATUS_RESET;
      effective_addr_q <= 32'h00000000;
      addr_reg_new_q <= 32'h00000000;
      addr_reg_we_q <= 1'b0;
      stack_ptr_new_q <= 32'h00000000;
      stack_ptr_we_q <= 1'b0;
      pc_new_q <= 32'h00000000;
      pc_we_q <= 1'b0;
      push_pc_addr_q <= 32'h00000000;
      push_sr_addr_q <= 32'h00000000;
      clocks_q <= 7'h00;
      reads_q <= 4'h0;
      writes_q <= 4'h0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (req_valid) begin
            result_q <= res_d;
            result_we_q <= res_we;
            status_out_q <= sr_d;
            effective_addr_q <= ea_d;
            addr_reg_new_q <= an_d;
            addr_reg_we_q <= an_we;
            stack_ptr_new_q <= sp_d;
            stack_ptr_we_q <= sp_we;
            pc_new_q <= pc_d;
            pc_we_q <= pc_we;
            push_pc_addr_q <= supervisor_stack_pointer - `STEP_LONG;
            push_sr_addr_q <= supervisor_stack_pointer - 32'h00000006;
            clocks_q <= ck_d;
            reads_q <= rd_d;
            writes_q <= wr_d;
            stop_pend_q <= stop_d;
            // hold busy for the whole cost, at least one clock
            wait_q <= (ck_d == 7'h00) ? 7'h00 : ck_d - 7'h01;
            busy_q <= 1'b1;
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (wait_q == 7'h00) begin
            done_q <= 1'b1;
            if (stop_pend_q) begin
              halted_q <= 1'b1;
              state_q <= ST_HALT;
            end else begin
              busy_q <= 1'b0;
              state_q <= ST_IDLE;
            end
          end else begin
            wait_q <= wait_q - 7'h01;
          end
        end
        ST_HALT: begin
          // only an outside wake-up leaves the stopped state
          if (resume) begin
            halted_q <= 1'b0;
            busy_q <= 1'b0;
            stop_pend_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

endmodule // exec_unit

/* File: exec_unit_chk.sv */
// port-level assertions for the execution unit
`timescale 1ns/1ps
`include "exec_consts.vh"
module exec_unit_chk (
  input wire clock,
  input wire rst_n,
  input wire clk_en,
  input wire req_valid,
  input wire [3:0] op_sel,
  input wire [1:0] op_size,
  input wire [3:0] ea_mode,
  input wire move_dst_ind,
  input wire [31:0] addr_reg,
  input wire [31:0] program_counter,
  input wire [15:0] ext_word0,
  input wire [31:0] supervisor_stack_pointer,
  input wire [31:0] trap_vector,
  input wire resume,
  input wire bus8_pin,
  input wire busy_q,
  input wire done_q,
  input wire halted_q,
  input wire [15:0] status_out_q,
  input wire [31:0] effective_addr_q,
  input wire [31:0] addr_reg_new_q,
  input wire addr_reg_we_q,
  input wire [31:0] pc_new_q,
  input wire pc_we_q,
  input wire [31:0] push_pc_addr_q,
  input wire [31:0] push_sr_addr_q,
  input wire [6:0] clocks_q,
  input wire [3:0] reads_q,
  input wire [3:0] writes_q
);
  // ****************************************
  // helper logic
  // ****************************************
  reg pin_q;
  reg [3:0] stab_q;
  // pin still longer than the synchroniser
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
      stab_q <= 4'h0;
    end else begin
      pin_q <= bus8_pin;
      stab_q <= (bus8_pin != pin_q) ? 4'h0 : ((stab_q == 4'h8) ? stab_q : stab_q + 4'h1);
    end
  end
  wire w16 = (stab_q == 4'h8) && !pin_q;
  wire w8 = (stab_q == 4'h8) && pin_q;
  wire acc = req_valid && !busy_q && !halted_q && clk_en;
  wire ea0 = acc && (op_sel == `OP_EA_CALC);
  wire lng = (op_size == `SZ_LONG);
  wire [31:0] sx16 = {{16{ext_word0[15]}}, ext_word0};
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ****************************************
  // assertions
  // ****************************************
  sequence s_ind_word;
    ea0 && (ea_mode == `EA_IND) && !lng && w16;
  endsequence
  sequence s_one_pulse;
    !done_q ##1 !done_q ##[1:3] done_q ##1 !done_q;
  endsequence
  AST_DONE: assert property (s_ind_word |=> s_one_pulse)
    else $error("done pulse misplaced");
  AST_IND: assert property (s_ind_word |=> clocks_q == 7'h04 && reads_q == 4'h1 && writes_q == 4'h0)
    else $error("indirect word cost wrong");
  AST_PREDEC: assert property (ea0 && ea_mode == `EA_PREDEC && lng && w16 |=> clocks_q == 7'h0b && reads_q == 4'h2 && addr_reg_we_q && addr_reg_new_q == $past(addr_reg) - 32'h4 && effective_addr_q == addr_reg_new_q)
    else $error("pre-decrement long wrong");
  AST_PCD: assert property (ea0 && ea_mode == `EA_PC_DISP && !lng && w16 |=> clocks_q == 7'h0b && reads_q == 4'h2 && effective_addr_q == $past(program_counter) + $past(sx16))
    else $error("pc displacement wrong");
  AST_INDEX: assert property (ea0 && ea_mode == `EA_INDEX && !lng && w16 |=> clocks_q == 7'h0e && reads_q == 4'h2)
    else $error("indexed cost wrong");
  AST_NARROW: assert property (ea0 && ea_mode == `EA_IND && lng && w8 |=> clocks_q == 7'h08 && reads_q == 4'h4)
    else $error("narrow reads not doubled");
  AST_MOVE: assert property (acc && op_sel == `OP_MOVE && move_dst_ind && !lng && w16 |=> clocks_q == 7'h0b && reads_q == 4'h1 && writes_q == 4'h1)
    else $error("move to indirect cost wrong");
  AST_TRAP: assert property (acc && op_sel == `OP_TRAP |=> pc_we_q && pc_new_q == $past(trap_vector) && push_pc_addr_q == $past(supervisor_stack_pointer) - 32'h4 && push_sr_addr_q == $past(supervisor_stack_pointer) - 32'h6)
    else $error("trap stacking wrong");
  AST_STOP: assert property (acc && op_sel == `OP_STOP |=> status_out_q == $past(ext_word0))
    else $error("stop status load wrong");
  AST_HALT: assert property (halted_q && !resume && clk_en |=> halted_q && busy_q && !done_q)
    else $error("halt left without resume");
endmodule // exec_unit_chk

/* File: stack_mem.sv */
// far-side memory answering the frame release pop
`timescale 1ns/1ps
module stack_mem (
  input wire [31:0] rd_addr,
  output reg [31:0] rd_data
);
  // per-address pattern so stale data shows
  always @* rd_data = {rd_addr[15:0], ~rd_addr[31:16]};
endmodule // stack_mem

/* File: exec_unit_tb_top.sv */
// self-checking bench for the execution unit
`timescale 1ns/1ps
`include "exec_consts.vh"
module exec_unit_tb_top;
  typedef struct packed {logic [6:0] ck; logic [3:0] rd; logic [3:0] wr; logic [2:0] k;
    logic [31:0] v1; logic [31:0] v2;} note_t;
  logic clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, req_valid = 1'b0, move_dst_ind = 1'b0;
  logic resume = 1'b0, bus8_pin = 1'b0, jitter = 1'b0;
  logic [3:0] op_sel, ea_mode;
  logic [1:0] op_size;
  logic [2:0] implied_sel = 3'h0;
  logic [31:0] src_operand, dst_operand, addr_reg, index_reg;
  logic [31:0] program_counter, user_stack_pointer, active_stack_pointer = 32'h0;
  logic [31:0] supervisor_stack_pointer, trap_vector;
  logic [15:0] ext_word0, ext_word1, status_reg;
  wire [31:0] pop_data, result_q, effective_addr_q, addr_reg_new_q, stack_ptr_new_q, pc_new_q;
  wire [31:0] push_pc_addr_q, push_sr_addr_q;
  wire [15:0] status_out_q;
  wire [6:0] clocks_q;
  wire [3:0] reads_q, writes_q;
  wire busy_q, done_q, halted_q, result_we_q, addr_reg_we_q, stack_ptr_we_q, pc_we_q;
  logic [31:0] seed = 32'h4309, s_src, s_dst, s_a, s_x, s_pc, s_e0, s_e1, s_sr, s_ssp, s_tv, r;
  logic [10:0] c;
  logic [15:0] st;
  logic b;
  int mismatches = 0, checks = 0, m, z, i;
  note_t n;
  note_t notes[$];
  always #50 clock = ~clock;
  exec_unit exec_unit_inst (.clock, .rst_n, .clk_en, .req_valid, .op_sel, .op_size, .ea_mode,
    .implied_sel, .move_dst_ind, .src_operand, .dst_operand, .addr_reg, .index_reg,
    .program_counter, .ext_word0, .ext_word1, .status_reg, .user_stack_pointer,
    .supervisor_stack_pointer, .active_stack_pointer, .trap_vector, .pop_data, .resume, .bus8_pin,
    .busy_q, .done_q, .halted_q, .result_q, .result_we_q, .status_out_q, .effective_addr_q,
    .addr_reg_new_q, .addr_reg_we_q, .stack_ptr_new_q, .stack_ptr_we_q, .pc_new_q, .pc_we_q,
    .push_pc_addr_q, .push_sr_addr_q, .clocks_q, .reads_q, .writes_q);
  stack_mem stack_mem_inst (.rd_addr(addr_reg), .rd_data(pop_data));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic prep;
    {s_src, s_dst, s_a, s_x, s_pc} = {rnd(), rnd(), rnd(), rnd(), rnd()};
    {s_e0, s_e1, s_sr, s_ssp, s_tv} = {rnd(), rnd(), rnd(), rnd(), rnd()};
  endtask
  // clocks and reads on a 16-bit bus
  function automatic logic [10:0] cost(input logic [3:0] md, input logic lg);
    case (md)
      `EA_IND, `EA_POSTINC, `EA_IMM: cost = lg ? {7'h08, 4'h2} : {7'h04, 4'h1};
      `EA_PREDEC: cost = lg ? {7'h0b, 4'h2} : {7'h07, 4'h1};
      `EA_DISP: cost = lg ? {7'h0c, 4'h3} : {7'h0b, 4'h2};
      `EA_INDEX: cost = lg ? {7'h08, 4'h3} : {7'h0e, 4'h2};
      `EA_ABS_S: cost = lg ? {7'h0c, 4'h3} : {7'h08, 4'h2};
      `EA_ABS_L: cost = lg ? {7'h10, 4'h4} : {7'h0c, 4'h3};
      `EA_PC_DISP: cost = lg ? {7'h0f, 4'h3} : {7'h0b, 4'h2};
      `EA_PC_INDEX: cost = lg ? {7'h10, 4'h4} : {7'h0e, 4'h2};
      default: cost = 11'h0;
    endcase
  endfunction
  function automatic logic [31:0] ea_exp(input logic [3:0] md, input logic [1:0] sz);
    logic [31:0] d16, d8;
    d16 = {{16{s_e0[15]}}, s_e0[15:0]};
    d8 = {{24{s_e0[7]}}, s_e0[7:0]};
    case (md)
      `EA_PREDEC: ea_exp = s_a - ((sz == `SZ_LONG) ? 32'h4 : (sz == `SZ_WORD) ? 32'h2 : 32'h1);
      `EA_DISP: ea_exp = s_a + d16;
      `EA_INDEX: ea_exp = s_a + s_x + d8;
      `EA_ABS_S: ea_exp = d16;
      `EA_ABS_L: ea_exp = {s_e0[15:0], s_e1[15:0]};
      `EA_PC_DISP: ea_exp = s_pc + d16;
      `EA_PC_INDEX: ea_exp = s_pc + s_x + d8;
      `EA_DREG: ea_exp = s_dst;
      default: ea_exp = s_a;
    endcase
  endfunction
  task automatic run(input logic [3:0] op, input logic [1:0] sz, input logic [3:0] md,
      input logic di, input note_t nt);
    int w;
    notes.push_back(nt);
    @(posedge clock);
    {op_sel, op_size, ea_mode, move_dst_ind, clk_en} <= {op, sz, md, di, 1'b1};
    {src_operand, dst_operand, addr_reg, index_reg, program_counter} <= {s_src, s_dst, s_a, s_x, s_pc};
    {ext_word0, ext_word1, status_reg} <= {s_e0[15:0], s_e1[15:0], s_sr[15:0]};
    {supervisor_stack_pointer, trap_vector, user_stack_pointer} <= {s_ssp, s_tv, s_x};
    req_valid <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
    for (w = 0; w < 80 && {done_q, clk_en} !== 2'b11; w++) begin
      @(posedge clock);
      clk_en <= ~jitter | seed[w % 32];
    end
    if (w == 80) begin
      mismatches = mismatches + 1;
      complete_run();
    end
  endtask
  // ****************************************
  // result monitor
  // ****************************************
  always @(posedge clock) begin
    if ({done_q, clk_en} === 2'b11) begin
      if (notes.size() == 0) chk(32'h1, 32'h0);
      else begin
        n = notes.pop_front();
        chk({25'h0, clocks_q}, {25'h0, n.ck});
        chk({28'h0, reads_q}, {28'h0, n.rd});
        chk({28'h0, writes_q}, {28'h0, n.wr});
        if (n.k == 3'h1) chk(result_q, n.v1);
        if (n.k == 3'h5) chk(effective_addr_q, n.v1);
        if (n.k == 3'h3) chk(pc_new_q, n.v1);
        if (n.k == 3'h4) chk(stack_ptr_new_q, n.v1);
        if (n.k == 3'h4) chk(addr_reg_new_q, n.v2);
        if (n.k == 3'h1 || n.k == 3'h2) chk({16'h0, status_out_q}, {16'h0, n.v2[15:0]});
        if (n.k == 3'h2) chk({31'h0, result_we_q}, 32'h0);
      end
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    for (m = 0; m < 13; m++) for (z = 0; z < 3; z++) begin
      prep();
      c = cost(m[3:0], z == 2);
      run(`OP_EA_CALC, z[1:0], m[3:0], 1'b0, {c, 4'h0,
        (m > 10) ? 3'h0 : 3'h5, ea_exp(m[3:0], z[1:0]), 32'h0});
    end
    $display("test addresses finished");
    run(`OP_MOVE, `SZ_WORD, `EA_DREG, 1'b0, {7'h07, 4'h1, 4'h0, 67'h0});
    run(`OP_MOVE, `SZ_BYTE, `EA_DREG, 1'b1, {7'h0b, 4'h1, 4'h1, 67'h0});
    bus8_pin <= 1'b1;
    repeat (8) @(posedge clock);
    run(`OP_EA_CALC, `SZ_LONG, `EA_IND, 1'b0, {7'h08, 4'h4, 4'h0, 67'h0});
    run(`OP_EA_CALC, `SZ_WORD, `EA_ABS_L, 1'b0, {7'h0c, 4'h6, 4'h0, 67'h0});
    run(`OP_MOVE, `SZ_WORD, `EA_DREG, 1'b1, {7'h0b, 4'h2, 4'h2, 67'h0});
    bus8_pin <= 1'b0;
    repeat (8) @(posedge clock);
    $display("test moves finished");
    jitter = 1'b1;
    for (i = 0; i < 4; i++) begin
      prep();
      s_src = s_dst;
      r = {s_dst[15:0], s_dst[31:16]};
      run(`OP_SWAP, `SZ_LONG, `EA_DREG, 1'b0, {15'h0, 3'h1, r,
        {16'h0, s_sr[15:4], r[31], r == 32'h0, 2'b00}});
      prep();
      if (i == 0) s_dst[7:0] = 8'h00;
      st = {s_sr[15:4], s_dst[7], s_dst[7:0] == 8'h00, 2'b00};
      run(`OP_TST, `SZ_BYTE, `EA_DREG, 1'b0, {15'h0, 3'h2, 32'h0, 16'h0, st});
      run(`OP_TAS, `SZ_BYTE, `EA_DREG, 1'b0, {15'h0, 3'h1, s_dst | 32'h80, 16'h0, st});
      if (i == 1) s_src = s_dst;
      {b, r} = {1'b0, s_dst} - {1'b0, s_src} - {32'h0, s_sr[4]};
      st = {s_sr[15:5], b, r[31], r == 32'h0, (s_dst[31] ^ s_src[31]) & (r[31] ^ s_dst[31]), b};
      run(`OP_MINUS_WITH_EXTEND, `SZ_LONG, `EA_DREG, 1'b0, {15'h0, 3'h1, r, 16'h0, st});
      run(`OP_TRAP, `SZ_WORD, `EA_IMPLIED, 1'b0, {15'h0, 3'h3, s_tv, 32'h0});
      run(`OP_FRAME_RELEASE, `SZ_LONG, `EA_AREG, 1'b0, {15'h0, 3'h4, s_a + 32'h4,
        {s_a[15:0], ~s_a[31:16]}});
    end
    jitter = 1'b0;
    $display("test operations finished");
    run(`OP_STOP, `SZ_WORD, `EA_IMPLIED, 1'b0, {15'h0, 3'h2, 48'h0, s_e0[15:0]});
    clk_en <= 1'b1;
    req_valid <= 1'b1;
    repeat (4) @(posedge clock);
    chk({31'h0, halted_q}, 32'h1);
    req_valid <= 1'b0;
    resume <= 1'b1;
    @(posedge clock);
    resume <= 1'b0;
    for (i = 0; i < 8 && busy_q !== 1'b0; i++) @(posedge clock);
    chk({30'h0, halted_q, busy_q}, 32'h0);
    repeat (4) @(posedge clock);
    chk(notes.size(), 32'h0);
    $display("test halt finished");
    complete_run();
  end
endmodule // exec_unit_tb_top
bind exec_unit exec_unit_chk exec_unit_chk_inst (.clock, .rst_n, .clk_en, .req_valid, .op_sel,
  .op_size, .ea_mode, .move_dst_ind, .addr_reg, .program_counter, .ext_word0,
  .supervisor_stack_pointer, .trap_vector, .resume, .bus8_pin, .busy_q, .done_q, .halted_q,
  .status_out_q, .effective_addr_q, .addr_reg_new_q, .addr_reg_we_q, .pc_new_q, .pc_we_q,
  .push_pc_addr_q, .push_sr_addr_q, .clocks_q, .reads_q, .writes_q);
